// ---- rtl/adc_result_buffer_sequencer.sv ----
`timescale 1ns/1ps

module adc_result_buffer_sequencer (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // register port
  input  wire logic [4:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [15:0] rdata,
  // converter core
  output logic             conv_start,
  output logic      [4:0]  conv_channel,
  input  wire logic        conv_done,
  input  wire logic [11:0] conv_result,
  // dma side
  output logic             dma_req,
  output logic      [15:0] dma_addr,
  // interrupt
  output logic             irq
);

  adc_seq_pkg::seq_state_t state_q;
  logic        on_q, auto_q, sample_start_bit_q, done_q;
  logic        alt_en_q, dma_en_q, opamp_q, scan_en_q;
  logic [3:0]  smpi_q, seq_cnt_q, ptr_q;
  logic [4:0]  ch_a_q, ch_b_q, scan_idx_q, dma_grp_q;
  logic [31:0] scan_list_q;
  logic [2:0]  stat_q, mask_q;
  logic [7:0]  sample_start_bit_cnt_q;
  logic        alt_sel_q, conv_alt_q, unread_q;
  logic [15:0] rdata_q, dma_addr_q;
  logic        conv_start_q, dma_req_q, irq_q;
  logic [4:0]  conv_ch_q;
  logic [11:0] buf_q [adc_seq_pkg::NUM_BUF];

  logic        wr_c1, wr_c2, wr_stat, rd_buf0;
  logic [31:0] scan_eff;
  logic [4:0]  scan_ch, sel_ch;
  logic        claimed, start_go, conv_fire, last_conv;
  logic [2:0]  stat_set;

  // lowest enabled entry at or after start, else lowest enabled entry overall
  function automatic logic [4:0] first_set(input logic [31:0] list, input logic [4:0] from);
    logic [4:0] r;
    logic [4:0] lo;
    logic       hit;
    r   = from;
    lo  = from;
    hit = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      if (list[i]) begin
        lo = 5'(i);
      end
      if (list[i] && (5'(i) >= from)) begin
        r   = 5'(i);
        hit = 1'b1;
      end
    end
    if (!hit) begin
      r = lo;
    end
    return r;
  endfunction : first_set

  // decode and channel choice
  assign wr_c1    = wr_en && (addr == adc_seq_pkg::CTRL1_ADDR);
  assign wr_c2    = wr_en && (addr == adc_seq_pkg::CTRL2_ADDR);
  assign wr_stat  = wr_en && (addr == adc_seq_pkg::STAT_ADDR);
  assign rd_buf0  = rd_en && (addr == adc_seq_pkg::BUF_BASE_ADDR);
  assign scan_eff = scan_list_q & (opamp_q ? ~adc_seq_pkg::CLAIM_MASK : 32'hFFFF_FFFF);
  assign scan_ch  = first_set(scan_eff, scan_idx_q);
  assign sel_ch   = alt_sel_q ? ch_b_q : (scan_en_q ? scan_ch : ch_a_q);
  assign claimed  = opamp_q && (sel_ch < adc_seq_pkg::CLAIM_PINS);
  assign start_go = (state_q == adc_seq_pkg::ST_SAMPLE) &&
                    (auto_q ? (sample_start_bit_cnt_q == adc_seq_pkg::SAMPLE_LAST) : !sample_start_bit_q);
  assign conv_fire = (state_q == adc_seq_pkg::ST_CONVERT) && conv_done;
  assign last_conv = (seq_cnt_q == smpi_q);

  // sequencer: idle, sample, convert
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q    <= adc_seq_pkg::ST_IDLE;
      sample_start_bit_cnt_q <= 8'h00;
    end else begin
      unique case (state_q)
        adc_seq_pkg::ST_IDLE: begin
          sample_start_bit_cnt_q <= 8'h00;
          if (on_q && (auto_q || sample_start_bit_q)) begin
            state_q <= adc_seq_pkg::ST_SAMPLE;
          end
        end
        adc_seq_pkg::ST_SAMPLE: begin
          sample_start_bit_cnt_q <= sample_start_bit_cnt_q + 8'h01;
          if (!on_q || (start_go && claimed)) begin
            state_q <= adc_seq_pkg::ST_IDLE; // a claimed input is never converted
          end else if (start_go) begin
            state_q <= adc_seq_pkg::ST_CONVERT;
          end
        end
        adc_seq_pkg::ST_CONVERT: begin
          if (conv_done) begin
            state_q <= adc_seq_pkg::ST_IDLE;
          end
        end
        default: begin
          state_q <= adc_seq_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // converter control one: on, auto sample, sample start, done
  always_ff @(posedge clk) begin
    if (rst) begin
      on_q   <= 1'b0;
      auto_q <= 1'b0;
      sample_start_bit_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      if (wr_c1) begin
        on_q   <= wdata[adc_seq_pkg::C1_ON];
        auto_q <= wdata[adc_seq_pkg::C1_AUTO];
        sample_start_bit_q <= wdata[adc_seq_pkg::C1_SAMPLE_START_BIT];
        done_q <= wdata[adc_seq_pkg::C1_DONE]; // software clear ahead of sampling
      end
      if (state_q == adc_seq_pkg::ST_IDLE && on_q && auto_q) begin
        sample_start_bit_q <= 1'b1;
      end
      if (start_go && auto_q) begin
        sample_start_bit_q <= 1'b0;
      end
      if (start_go && !claimed) begin
        done_q <= 1'b0; // a real start or a control one write with bit C1_DONE low clears it, a claimed start does not
      end
      if (conv_fire) begin
        done_q <= 1'b1; // holds through next sampling
      end
    end
  end

  // converter control two, channel select and scan list
  always_ff @(posedge clk) begin
    if (rst) begin
      alt_en_q    <= 1'b0;
      smpi_q      <= 4'h0;
      dma_en_q    <= 1'b0;
      opamp_q     <= 1'b0;
      scan_en_q   <= 1'b0;
      ch_a_q      <= 5'h00;
      ch_b_q      <= 5'h00;
      scan_list_q <= adc_seq_pkg::SCAN_RST;
      mask_q      <= adc_seq_pkg::STAT_RST;
    end else if (wr_en) begin
      if (addr == adc_seq_pkg::CTRL2_ADDR) begin
        alt_en_q  <= wdata[adc_seq_pkg::C2_ALT];
        smpi_q    <= wdata[adc_seq_pkg::C2_SMPI_LSB +: adc_seq_pkg::SMPI_W];
        dma_en_q  <= wdata[adc_seq_pkg::C2_DMA];
        opamp_q   <= wdata[adc_seq_pkg::C2_OPAMP];
        scan_en_q <= wdata[adc_seq_pkg::C2_SCAN];
      end
      if (addr == adc_seq_pkg::CHSEL_ADDR) begin
        ch_a_q <= wdata[adc_seq_pkg::CHA_LSB +: adc_seq_pkg::CH_W];
        ch_b_q <= wdata[adc_seq_pkg::CHB_LSB +: adc_seq_pkg::CH_W];
      end
      if (addr == adc_seq_pkg::SCAN_LO_ADDR) begin
        scan_list_q[15:0] <= wdata;
      end
      if (addr == adc_seq_pkg::SCAN_HI_ADDR) begin
        scan_list_q[31:16] <= wdata;
      end
      if (addr == adc_seq_pkg::MASK_ADDR) begin
        mask_q <= wdata[adc_seq_pkg::ST_W-1:0];
      end
    end
  end

  // conversion launch toward the core
  always_ff @(posedge clk) begin
    if (rst) begin
      conv_start_q <= 1'b0;
      conv_ch_q    <= 5'h00;
      conv_alt_q   <= 1'b0;
    end else begin
      conv_start_q <= start_go && !claimed;
      if (start_go && !claimed) begin
        conv_ch_q  <= sel_ch;
        conv_alt_q <= alt_sel_q;
      end
    end
  end

  // interval counter, scan position and alternate half
  always_ff @(posedge clk) begin
    if (rst) begin
      seq_cnt_q  <= 4'h0;
      scan_idx_q <= 5'h00;
      alt_sel_q  <= 1'b0;
    end else if (wr_c2) begin
      seq_cnt_q  <= 4'h0; // a new setting starts a fresh interval
      scan_idx_q <= 5'h00;
      alt_sel_q  <= 1'b0;
    end else if (conv_fire) begin
      seq_cnt_q <= last_conv ? 4'h0 : seq_cnt_q + 4'h1;
      alt_sel_q <= alt_en_q && !alt_sel_q && !last_conv;
      if (last_conv) begin
        scan_idx_q <= 5'h00; // list restarts at its first entry
      end else if (!conv_alt_q) begin
        scan_idx_q <= conv_ch_q + 5'h01;
      end
    end
  end

  // result placement by sequence position only
  always_ff @(posedge clk) begin
    if (rst) begin
      ptr_q <= 4'h0;
    end else if (wr_c2 || dma_en_q) begin
      ptr_q <= 4'h0; // dma mode keeps the pointer on the first buffer
    end else if (conv_fire) begin
      ptr_q <= last_conv ? 4'h0 : ptr_q + 4'h1;
    end
  end

  // result storage, one word per buffer; cleared at reset so a slot never written reads as zero
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < adc_seq_pkg::NUM_BUF; i++) begin
        buf_q[i] <= 12'h000;
      end
    end else if (conv_fire) begin
      buf_q[dma_en_q ? 4'h0 : ptr_q] <= conv_result;
    end
  end

  // dma request and address pointer
  always_ff @(posedge clk) begin
    if (rst) begin
      dma_req_q  <= 1'b0;
      dma_grp_q  <= 5'h00;
      dma_addr_q <= 16'h0000;
      unread_q   <= 1'b0;
    end else begin
      dma_req_q <= conv_fire && dma_en_q;
      if (conv_fire && dma_en_q) begin
        dma_grp_q <= dma_grp_q + 5'h01;
        if (dma_grp_q == adc_seq_pkg::DMA_GRP_LAST) begin
          dma_addr_q <= dma_addr_q + 16'h0001;
        end
      end
      if (rd_buf0 || !dma_en_q) begin
        unread_q <= 1'b0;
      end
      if (conv_fire && dma_en_q) begin
        unread_q <= 1'b1; // a landing result wins over a read in the same cycle
      end
    end
  end

  // sticky status events
  always_comb begin
    stat_set = 3'h0;
    stat_set[adc_seq_pkg::ST_INTERVAL] = conv_fire && last_conv;
    stat_set[adc_seq_pkg::ST_OVERRUN]  = conv_fire && dma_en_q && unread_q;
    stat_set[adc_seq_pkg::ST_CLAIM]    = start_go && claimed;
  end

  // write one to clear, a set in the same cycle wins
  always_ff @(posedge clk) begin
    if (rst) begin
      stat_q <= adc_seq_pkg::STAT_RST;
    end else begin
      stat_q <= (stat_q & ~(wr_stat ? wdata[adc_seq_pkg::ST_W-1:0] : 3'h0)) | stat_set;
    end
  end

  // level interrupt, one cycle behind the status
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(stat_q & mask_q);
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= 16'h0000;
    end else if (!rd_en) begin
      rdata_q <= 16'h0000;
    end else if (addr >= adc_seq_pkg::BUF_BASE_ADDR) begin
      rdata_q <= {4'h0, buf_q[addr[3:0]]};
    end else begin
      unique case (addr)
        adc_seq_pkg::CTRL1_ADDR:   rdata_q <= {on_q, 12'h000, auto_q, sample_start_bit_q, done_q};
        adc_seq_pkg::CTRL2_ADDR:   rdata_q <= {5'h00, scan_en_q, opamp_q, dma_en_q,
                                               2'h0, smpi_q, 1'b0, alt_en_q};
        adc_seq_pkg::CHSEL_ADDR:   rdata_q <= {3'h0, ch_b_q, 3'h0, ch_a_q};
        adc_seq_pkg::SCAN_LO_ADDR: rdata_q <= scan_list_q[15:0];
        adc_seq_pkg::SCAN_HI_ADDR: rdata_q <= scan_list_q[31:16];
        adc_seq_pkg::STAT_ADDR:    rdata_q <= {13'h0000, stat_q};
        adc_seq_pkg::MASK_ADDR:    rdata_q <= {13'h0000, mask_q};
        adc_seq_pkg::DMA_PTR_ADDR: rdata_q <= dma_addr_q;
        default:                   rdata_q <= 16'h0000; // unmapped reads as zero
      endcase
    end
  end

  assign rdata        = rdata_q;
  assign conv_start   = conv_start_q;
  assign conv_channel = conv_ch_q;
  assign dma_req      = dma_req_q;
  assign dma_addr     = dma_addr_q;
  assign irq          = irq_q;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_good_start;
    start_go && !claimed;
  endsequence
  sequence s_launch;
    conv_start_q && !done_q ##1 !conv_start_q;
  endsequence

  chk_done_at_start: assert property (s_good_start |=> s_launch)
    else $error("start did not pulse once with done cleared");
  chk_done_at_end: assert property (conv_fire |=> done_q)
    else $error("done not set at end of conversion");
  chk_done_holds: assert property (done_q && !start_go && !wr_c1 |=> done_q)
    else $error("done dropped before next conversion began");
  chk_interval_flag: assert property (conv_fire && last_conv |=>
      stat_q[adc_seq_pkg::ST_INTERVAL] && seq_cnt_q == 4'h0 ##1 irq_q == mask_q[0])
    else $error("interval end did not flag");
  chk_buffer_wrap: assert property (conv_fire && last_conv && !dma_en_q && !wr_c2
      |=> ptr_q == 4'h0)
    else $error("buffer pointer did not return to first buffer");
  chk_buffer_step: assert property (conv_fire && !last_conv && !dma_en_q && !wr_c2
      |=> ptr_q == 4'($past(ptr_q) + 4'h1))
    else $error("buffer pointer did not step by one");
  chk_dma_single: assert property (dma_en_q |=> ptr_q == 4'h0)
    else $error("dma mode left the first buffer");
  chk_dma_group: assert property (conv_fire && dma_en_q && dma_grp_q == 5'h1F
      |=> dma_addr_q == 16'($past(dma_addr_q) + 16'h0001) ##1 dma_grp_q == 5'h00)
    else $error("dma address did not advance after group");
  chk_scan_restart: assert property (conv_fire && last_conv && !wr_c2
      |=> scan_idx_q == 5'h00)
    else $error("scan list did not restart");
  chk_claim_block: assert property (start_go && claimed |=> !conv_start_q
      && stat_q[adc_seq_pkg::ST_CLAIM])
    else $error("claimed input was converted");

endmodule : adc_result_buffer_sequencer

// ---- rtl/adc_seq_pkg.sv ----
package adc_seq_pkg;

  // widths
  localparam int unsigned DATA_W  = 16;
  localparam int unsigned ADDR_W  = 5;
  localparam int unsigned RES_W   = 12;
  localparam int unsigned CH_W    = 5;
  localparam int unsigned NUM_CH  = 32;
  localparam int unsigned NUM_BUF = 16;
  localparam int unsigned PTR_W   = 4;
  localparam int unsigned SMPI_W  = 4;
  localparam int unsigned ST_W    = 3;

  // register offsets on the plain register port
  localparam logic [4:0] CTRL1_ADDR    = 5'h00; // converter_control_one
  localparam logic [4:0] CTRL2_ADDR    = 5'h01; // converter_control_two
  localparam logic [4:0] CHSEL_ADDR    = 5'h02;
  localparam logic [4:0] SCAN_LO_ADDR  = 5'h03; // scan_select_low
  localparam logic [4:0] SCAN_HI_ADDR  = 5'h04; // scan_select_high
  localparam logic [4:0] STAT_ADDR     = 5'h05;
  localparam logic [4:0] MASK_ADDR     = 5'h06;
  localparam logic [4:0] DMA_PTR_ADDR  = 5'h07;
  localparam logic [4:0] BUF_BASE_ADDR = 5'h10; // result_buffer_first .. result_buffer_last

  // field positions
  localparam int unsigned C1_DONE     = 0;
  localparam int unsigned C1_SAMPLE_START_BIT     = 1;  // sample_start_bit
  localparam int unsigned C1_AUTO     = 2;
  localparam int unsigned C1_ON       = 15;
  localparam int unsigned C2_ALT      = 0;
  localparam int unsigned C2_SMPI_LSB = 2;  // samples_per_interrupt
  localparam int unsigned C2_DMA      = 8;  // dma_result_mode_enable
  localparam int unsigned C2_OPAMP    = 9;
  localparam int unsigned C2_SCAN     = 10; // scan_inputs_enable
  localparam int unsigned CHA_LSB     = 0;  // primary_input_mux
  localparam int unsigned CHB_LSB     = 8;
  localparam int unsigned ST_INTERVAL = 0;
  localparam int unsigned ST_OVERRUN  = 1;
  localparam int unsigned ST_CLAIM    = 2;

  // values after reset
  localparam logic [15:0] REG_RST   = 16'h0000;
  localparam logic [31:0] SCAN_RST  = 32'h0000_0000;
  localparam logic [2:0]  STAT_RST  = 3'h0;

  // pins claimed by the second op amp
  localparam logic [31:0] CLAIM_MASK = 32'h0000_0007;
  localparam logic [4:0]  CLAIM_PINS = 5'h03;

  // automatic sample time
  localparam int unsigned CLK_PERIOD_PS  = 5000;
  localparam int unsigned SAMPLE_TIME_NS = 100;
  localparam int unsigned SAMPLE_CYCLES  =
    (SAMPLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [7:0]  SAMPLE_LAST    = 8'(SAMPLE_CYCLES - 1);

  // dma address advances once per group of conversions
  localparam logic [4:0]  DMA_GRP_LAST = 5'h1F;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_SAMPLE  = 2'b01,
    ST_CONVERT = 2'b11
  } seq_state_t;

endpackage : adc_seq_pkg

// ---- verification/adc_core_model.sv ----
`timescale 1ns/1ps

// converter core stand-in: answers each start lat+1 cycles after it is seen, with a tagged result
module adc_core_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // start side
  input  wire logic        conv_start,
  input  wire logic [4:0]  conv_channel,
  input  wire logic [3:0]  lat,
  // result side
  output logic             conv_done,
  output logic      [11:0] conv_result
);
  logic       busy_q;
  logic [3:0] cnt_q;
  logic [6:0] seq_q;
  logic [4:0] ch_q;

  // result carries a running count and the channel so every sample is unique;
  // outside the done pulse the bus toggles so a stale value never looks valid
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_q      <= 1'b0;
      cnt_q       <= 4'h0;
      seq_q       <= 7'h00;
      ch_q        <= 5'h00;
      conv_done   <= 1'b0;
      conv_result <= 12'hFFF;
    end else begin
      conv_done   <= 1'b0;
      conv_result <= ~conv_result;
      if (conv_start) begin
        busy_q <= 1'b1;
        cnt_q  <= lat;
        ch_q   <= conv_channel;
      end else if (busy_q && cnt_q == 4'h0) begin
        busy_q      <= 1'b0;
        conv_done   <= 1'b1;
        conv_result <= {seq_q, ch_q};
        seq_q       <= seq_q + 7'h01;
      end else if (busy_q) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule : adc_core_model

// ---- verification/tb.sv ----
`timescale 1ns/1ps

module tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [4:0]  addr = 5'h00;
  logic [15:0] wdata = 16'h0000;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic [15:0] rdata;
  logic        conv_start;
  logic [4:0]  conv_channel;
  logic        conv_done;
  logic [11:0] conv_result;
  logic        dma_req;
  logic [15:0] dma_addr;
  logic        irq;
  logic [3:0]  lat = 4'h3;
  int          miscompares = 0;
  int          tests_run = 0;
  int          n_done = 0;
  int          n_start = 0;
  logic [11:0] res_log [0:255];
  logic [4:0]  chan_log [0:255];

  // 200 MHz clock
  always #2.5 clk = ~clk;

  adc_result_buffer_sequencer i_adc_result_buffer_sequencer (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .conv_start(conv_start), .conv_channel(conv_channel),
    .conv_done(conv_done), .conv_result(conv_result), .dma_req(dma_req),
    .dma_addr(dma_addr), .irq(irq));

  adc_core_model i_adc_core_model (
    .clk(clk), .rst(rst), .conv_start(conv_start), .conv_channel(conv_channel),
    .lat(lat), .conv_done(conv_done), .conv_result(conv_result));

  // log every launch and every finished conversion
  always @(posedge clk) begin
    if (!rst && conv_start) begin
      chan_log[n_start[7:0]] = conv_channel;
      n_start++;
    end
    if (!rst && conv_done) begin
      res_log[n_done[7:0]] = conv_result;
      n_done++;
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask : rd

  task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp, input string msg);
    logic [15:0] d;
    rd(a, d);
    chk(d, exp, msg);
  endtask : rd_chk

  // bounded wait on the launch count (sel=1) or the result count (sel=0)
  task automatic wait_n(input logic sel, input int target);
    int k;
    k = 0;
    while (((sel ? n_start : n_done) < target) && k < 2000) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk(16'(k >= 2000), 16'h0000, "wait timed out");
  endtask : wait_n

  task automatic settle2;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle2

  task automatic t_reset;
    rd_chk(adc_seq_pkg::CTRL1_ADDR, adc_seq_pkg::REG_RST, "ctrl1 reset");
    rd_chk(adc_seq_pkg::CTRL2_ADDR, adc_seq_pkg::REG_RST, "ctrl2 reset");
    rd_chk(5'h08, 16'h0000, "unmapped read");
    chk(rdata, 16'h0000, "rdata idle");
  endtask : t_reset

  // manual mode: done clears at start, is set when the conversion ends, and survives the next sample phase
  task automatic t_manual;
    lat = 4'hA;
    wr(adc_seq_pkg::CHSEL_ADDR, 16'h0005);
    wr(adc_seq_pkg::CTRL1_ADDR, 16'h8002);
    wr(adc_seq_pkg::CTRL1_ADDR, 16'h8000);
    wait_n(1'b1, 1);
    rd_chk(adc_seq_pkg::CTRL1_ADDR, 16'h8000, "done during convert");
    wait_n(1'b0, 1);
    settle2();
    rd_chk(adc_seq_pkg::CTRL1_ADDR, 16'h8001, "done after convert");
    wr(adc_seq_pkg::CTRL1_ADDR, 16'h8003);
    rd_chk(adc_seq_pkg::CTRL1_ADDR, 16'h8003, "done in sample");
    wr(adc_seq_pkg::CTRL1_ADDR, 16'h8001);
    wait_n(1'b1, 2);
    rd_chk(adc_seq_pkg::CTRL1_ADDR, 16'h8000, "done at next start");
    wait_n(1'b0, 2);
    settle2();
    rd_chk(adc_seq_pkg::BUF_BASE_ADDR, {4'h0, res_log[1]}, "manual result");
  endtask : t_manual

  // scan of five channels with an interval of three, plus interrupt mask and clear
  task automatic t_scan;
    int b;
    logic [4:0] ch [0:5];
    ch = '{5'h04, 5'h05, 5'h06, 5'h04, 5'h05, 5'h06};
    b = n_done;
    lat = 4'h3;
    wr(adc_seq_pkg::STAT_ADDR, 16'h0007);
    wr(adc_seq_pkg::SCAN_LO_ADDR, 16'h01F0);
    wr(adc_seq_pkg::MASK_ADDR, 16'h0001);
    wr(adc_seq_pkg::CTRL2_ADDR, 16'h0408);
    wr(adc_seq_pkg::CTRL1_ADDR, 16'h8004);
    wait_n(1'b0, b + 2);
    settle2();
    chk(16'(irq), 16'h0000, "irq before interval");
    wait_n(1'b0, b + 3);
    settle2();
    chk(16'(irq), 16'h0001, "irq at interval");
    wait_n(1'b0, b + 6);
    wr(adc_seq_pkg::CTRL1_ADDR, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      chk(16'(chan_log[b + i]), 16'(ch[i]), "scan channel");
    end
    for (int i = 0; i < 3; i++) begin
      rd_chk(5'(adc_seq_pkg::BUF_BASE_ADDR + i), {4'h0, res_log[b + 3 + i]}, "wrap");
    end
    rd_chk(5'(adc_seq_pkg::BUF_BASE_ADDR + 3), 16'h0000, "beyond interval");
    wr(adc_seq_pkg::MASK_ADDR, 16'h0000);
    settle2();
    chk(16'(irq), 16'h0000, "irq masked");
    wr(adc_seq_pkg::MASK_ADDR, 16'h0001);
    settle2();
    chk(16'(irq), 16'h0001, "irq unmasked");
    wr(adc_seq_pkg::STAT_ADDR, 16'h0001);
    settle2();
    chk(16'(irq), 16'h0000, "irq cleared");
  endtask : t_scan

  // second op amp holds the three lowest inputs
  task automatic t_opamp;
    int s;
    s = n_start;
    wr(adc_seq_pkg::CTRL2_ADDR, 16'h0200);
    wr(adc_seq_pkg::CHSEL_ADDR, 16'h0002);
    wr(adc_seq_pkg::CTRL1_ADDR, 16'h8002);
    wr(adc_seq_pkg::CTRL1_ADDR, 16'h8000);
    repeat (30) @(posedge clk);
    #1;
    chk(16'(n_start - s), 16'h0000, "claimed channel started");
    rd_chk(adc_seq_pkg::STAT_ADDR, 16'h0004, "claim status");
    wr(adc_seq_pkg::STAT_ADDR, 16'h0004);
    wr(adc_seq_pkg::CHSEL_ADDR, 16'h0003);
    wr(adc_seq_pkg::CTRL1_ADDR, 16'h8002);
    wr(adc_seq_pkg::CTRL1_ADDR, 16'h8000);
    wait_n(1'b1, s + 1);
    chk(16'(chan_log[s]), 16'h0003, "free channel");
    wait_n(1'b0, n_start);
  endtask : t_opamp

  // dma mode: single buffer read after every request, address steps per 32
  task automatic t_dma;
    int b;
    int k;
    logic [15:0] keep;
    rd(5'(adc_seq_pkg::BUF_BASE_ADDR + 1), keep);
    b = n_done;
    lat = 4'hC;
    wr(adc_seq_pkg::CTRL2_ADDR, 16'h0100);
    wr(adc_seq_pkg::CHSEL_ADDR, 16'h0009);
    wr(adc_seq_pkg::CTRL1_ADDR, 16'h8004);
    for (int i = 0; i < 32; i++) begin
      wait_n(1'b0, b + i + 1);
      k = 0;
      while (dma_req !== 1'b1 && k < 10) begin
        @(posedge clk);
        #1;
        k++;
      end
      chk(16'(k < 10), 16'h0001, "dma request");
      rd_chk(adc_seq_pkg::BUF_BASE_ADDR, {4'h0, res_log[b + i]}, "dma buffer");
      if (i == 30) chk(dma_addr, 16'h0000, "dma addr early");
      if (i == 31) chk(dma_addr, 16'h0001, "dma addr step");
    end
    wr(adc_seq_pkg::CTRL1_ADDR, 16'h0000);
    rd_chk(5'(adc_seq_pkg::BUF_BASE_ADDR + 1), keep, "second buffer");
    rd_chk(adc_seq_pkg::STAT_ADDR, 16'h0001, "no overrun");
  endtask : t_dma

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude

  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_manual();
    t_scan();
    t_opamp();
    t_dma();
    conclude();
  end

  // watchdog: the run needs under two thousand cycles
  initial begin
    #100000;
    miscompares++;
    conclude();
  end
endmodule : tb
